// [bbod_pkg.sv]
// constants, types and helpers for the branch / bit-op decode block
// assumes a core clock with four phases per instruction cycle
`default_nettype none
package bbod_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int INSTR_W = 16;
  localparam int PC_W = 21;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int BANK_W = 4;
  localparam int OFF_W = 11;

  // ---------------------------------------------------------------
  // opcode patterns and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_BR_NOT_OVF = 8'he5;
  localparam logic [7:0] OPC_BR_NOT_ZERO = 8'he1;
  localparam logic [4:0] OPC_BR_ALWAYS = 5'h1a;
  localparam logic [3:0] OPC_BIT_SET = 4'h8;
  localparam logic [3:0] OPC_BIT_SKIP_CLR = 4'hb;
  localparam int FLD_BIT_LSB = 9;
  localparam int FLD_BANK_A = 8;
  localparam int FLD_FADDR_LSB = 0;

  // ---------------------------------------------------------------
  // fixed access bank layout
  // ---------------------------------------------------------------
  localparam int ACCESS_SPLIT_BIT = 7;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

  // ---------------------------------------------------------------
  // cycle counts
  // ---------------------------------------------------------------
  localparam logic [1:0] NOP_AFTER_TAKEN = 2'h1;
  localparam logic [1:0] NOP_AFTER_SKIP_TWO_WORD = 2'h2;
  localparam logic [1:0] NOP_NONE = 2'h0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} bbod_phase_t;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_BRANCH_NOT_OVERFLOW,
    OP_BRANCH_NOT_ZERO,
    OP_BRANCH_ALWAYS,
    OP_BIT_SET_FILE,
    OP_BIT_TEST_SKIP_CLEAR
  } bbod_op_t;

  typedef struct packed {
    bbod_phase_t phase;
    logic [1:0] nop_left;
    bbod_op_t op;
    logic [2:0] bitpos;
    logic bank_a;
    logic [7:0] faddr;
    logic [OFF_W-1:0] off;
    logic [PC_W-1:0] pc_base;
    logic taken;
    logic nop_cycle;
    logic mem_rd;
    logic mem_wr;
    logic [ADDR_W-1:0] mem_addr;
    logic [DATA_W-1:0] wdata;
    logic pc_load;
    logic [PC_W-1:0] pc_target;
    logic flush;
    logic status_we;
  } bbod_state_t;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [DATA_W-1:0] bit_mask(input logic [2:0] pos);
    bit_mask = 8'h01 << pos;
  endfunction

endpackage
`default_nettype wire

// [bbod_dec_if.sv]
// carrier between the sequencer and the opcode decoder
// assumes both ends sit on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface bbod_dec_if;
  logic [bbod_pkg::INSTR_W-1:0] word;
  bbod_pkg::bbod_op_t op;
  logic [2:0] bitpos;
  logic bank_a;
  logic [7:0] faddr;
  logic [bbod_pkg::OFF_W-1:0] off;

  modport ctl (output word, input op, input bitpos, input bank_a, input faddr, input off);
  modport dec (input word, output op, output bitpos, output bank_a, output faddr, output off);
endinterface
`default_nettype wire

// [bbod_decode.sv]
// combinational opcode decoder for the branch and bit-op group
// assumes the word is stable while the sequencer samples the result
`timescale 1ns/1ps
`default_nettype none
module bbod_decode (
  bbod_dec_if.dec dif
);

  always_comb begin
    dif.op = bbod_pkg::OP_NONE;
    dif.bitpos = dif.word[bbod_pkg::FLD_BIT_LSB +: 3];
    dif.bank_a = dif.word[bbod_pkg::FLD_BANK_A];
    dif.faddr = dif.word[bbod_pkg::FLD_FADDR_LSB +: 8];
    // 8-bit offset sign-extended unless the long form matches
    dif.off = {{3{dif.word[7]}}, dif.word[7:0]};
    if (dif.word[15:8] == bbod_pkg::OPC_BR_NOT_OVF) begin
      dif.op = bbod_pkg::OP_BRANCH_NOT_OVERFLOW;
    end else if (dif.word[15:8] == bbod_pkg::OPC_BR_NOT_ZERO) begin
      dif.op = bbod_pkg::OP_BRANCH_NOT_ZERO;
    end else if (dif.word[15:11] == bbod_pkg::OPC_BR_ALWAYS) begin
      dif.op = bbod_pkg::OP_BRANCH_ALWAYS;
      dif.off = dif.word[10:0];
    end else if (dif.word[15:12] == bbod_pkg::OPC_BIT_SET) begin
      dif.op = bbod_pkg::OP_BIT_SET_FILE;
    end else if (dif.word[15:12] == bbod_pkg::OPC_BIT_SKIP_CLR) begin
      dif.op = bbod_pkg::OP_BIT_TEST_SKIP_CLEAR;
    end
  end

endmodule // bbod_decode
`default_nettype wire

// [bbod_core.sv]
// branch and bit-op execute sequencer for an 8-bit core
// assumes fetch, flags, bank select and data memory share clk_in
//
// Behaviour
// - Pattern e5 with 8-bit offset branches only when overflow is clear.
// - Pattern e1 with 8-bit offset branches only when zero is clear.
// - A taken branch adds twice the signed offset to the already incremented pc.
// - A conditional branch takes one cycle if not taken, else two with pc written in q4 and a nop cycle.
// - Pattern 11010 with 11-bit offset branches always, target computed the same way.
// - The unconditional branch always takes two cycles, the second a nop.
// - Pattern 1000 sets the selected bit of the addressed file register in one cycle.
// - Bank bit 0 selects the fixed access bank, bank bit 1 the bank select register.
// - Pattern 1011 reads the register and skips the next instruction if the bit is 0.
// - A skip discards the prefetched instruction and runs a nop cycle instead.
// - A skip over a two-word instruction inserts two nop cycles, three cycles in all.
`timescale 1ns/1ps
`default_nettype none
module bbod_core (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic [bbod_pkg::INSTR_W-1:0] instr_in,
  input wire logic [bbod_pkg::PC_W-1:0] pc_next_in,
  input wire logic two_word_next_in,
  input wire logic ovf_flag_in,
  input wire logic zero_flag_in,
  input wire logic [bbod_pkg::BANK_W-1:0] bank_select_register_in,
  input wire logic [bbod_pkg::DATA_W-1:0] rdata_in,
  output logic [1:0] phase_out,
  output logic nop_cycle_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic [bbod_pkg::ADDR_W-1:0] mem_addr_out,
  output logic [bbod_pkg::DATA_W-1:0] mem_wdata_out,
  output logic pc_load_out,
  output logic [bbod_pkg::PC_W-1:0] pc_target_out,
  output logic flush_out,
  output logic status_we_out
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rstn;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rstn = rst_sync_reg[1];

  // ---------------------------------------------------------------
  // decoder
  // ---------------------------------------------------------------
  bbod_dec_if dif ();

  assign dif.word = instr_in;

  bbod_decode u_decode (
    .dif(dif)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [bbod_pkg::ADDR_W-1:0] file_addr(
    input logic bank_a,
    input logic [7:0] faddr,
    input logic [bbod_pkg::BANK_W-1:0] bank_sel
  );
    logic [bbod_pkg::BANK_W-1:0] bank;
    if (bank_a) begin
      bank = bank_sel;
    end else if (faddr[bbod_pkg::ACCESS_SPLIT_BIT]) begin
      bank = bbod_pkg::ACCESS_HIGH_BANK;
    end else begin
      bank = bbod_pkg::ACCESS_LOW_BANK;
    end
    file_addr = {bank, faddr};
  endfunction

  function automatic logic [bbod_pkg::PC_W-1:0] rel_target(
    input logic [bbod_pkg::PC_W-1:0] base,
    input logic [bbod_pkg::OFF_W-1:0] off
  );
    logic [bbod_pkg::PC_W-1:0] step;
    step = {{(bbod_pkg::PC_W - bbod_pkg::OFF_W - 1){off[bbod_pkg::OFF_W-1]}}, off, 1'b0};
    rel_target = base + step;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  bbod_pkg::bbod_state_t s_reg;
  bbod_pkg::bbod_state_t s_next;
  logic exec_now;
  logic is_branch;

  assign exec_now = (s_reg.nop_left == bbod_pkg::NOP_NONE);
  assign is_branch = (s_reg.op == bbod_pkg::OP_BRANCH_NOT_OVERFLOW) ||
                     (s_reg.op == bbod_pkg::OP_BRANCH_NOT_ZERO) ||
                     (s_reg.op == bbod_pkg::OP_BRANCH_ALWAYS);

  always_comb begin
    s_next = s_reg;
    s_next.mem_rd = 1'b0;
    s_next.mem_wr = 1'b0;
    s_next.pc_load = 1'b0;
    s_next.flush = 1'b0;
    s_next.status_we = 1'b0;
    unique case (s_reg.phase)
      bbod_pkg::PH_Q1: begin
        s_next.phase = bbod_pkg::PH_Q2;
        if (exec_now) begin
          s_next.op = dif.op;
          s_next.bitpos = dif.bitpos;
          s_next.bank_a = dif.bank_a;
          s_next.faddr = dif.faddr;
          s_next.off = dif.off;
          s_next.pc_base = pc_next_in;
          s_next.taken = 1'b0;
          s_next.mem_addr = file_addr(dif.bank_a, dif.faddr, bank_select_register_in);
          s_next.mem_rd = (dif.op == bbod_pkg::OP_BIT_SET_FILE) ||
                          (dif.op == bbod_pkg::OP_BIT_TEST_SKIP_CLEAR);
        end else begin
          s_next.op = bbod_pkg::OP_NONE;
        end
      end
      bbod_pkg::PH_Q2: begin
        s_next.phase = bbod_pkg::PH_Q3;
      end
      bbod_pkg::PH_Q3: begin
        s_next.phase = bbod_pkg::PH_Q4;
        unique case (s_reg.op)
          bbod_pkg::OP_BRANCH_NOT_OVERFLOW: s_next.taken = !ovf_flag_in;
          bbod_pkg::OP_BRANCH_NOT_ZERO: s_next.taken = !zero_flag_in;
          bbod_pkg::OP_BRANCH_ALWAYS: s_next.taken = 1'b1;
          bbod_pkg::OP_BIT_TEST_SKIP_CLEAR: s_next.taken = !rdata_in[s_reg.bitpos];
          bbod_pkg::OP_BIT_SET_FILE: s_next.taken = 1'b0;
          bbod_pkg::OP_NONE: s_next.taken = 1'b0;
          default: s_next.taken = 1'b0;
        endcase
        if (exec_now && is_branch && s_next.taken) begin
          s_next.pc_load = 1'b1;
          s_next.pc_target = rel_target(s_reg.pc_base, s_reg.off);
        end
        if (exec_now && s_reg.op == bbod_pkg::OP_BIT_SET_FILE) begin
          s_next.mem_wr = 1'b1;
          s_next.wdata = rdata_in | bbod_pkg::bit_mask(s_reg.bitpos);
        end
        s_next.flush = s_next.taken;
      end
      bbod_pkg::PH_Q4: begin
        s_next.phase = bbod_pkg::PH_Q1;
        if (!exec_now) begin
          s_next.nop_left = s_reg.nop_left - 2'h1;
        end else if (s_reg.taken) begin
          if (s_reg.op == bbod_pkg::OP_BIT_TEST_SKIP_CLEAR && two_word_next_in) begin
            s_next.nop_left = bbod_pkg::NOP_AFTER_SKIP_TWO_WORD;
          end else begin
            s_next.nop_left = bbod_pkg::NOP_AFTER_TAKEN;
          end
        end
        s_next.taken = 1'b0;
        s_next.nop_cycle = (s_next.nop_left != bbod_pkg::NOP_NONE);
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
    end else if (ce_in) begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign phase_out = s_reg.phase;
  assign nop_cycle_out = s_reg.nop_cycle;
  assign mem_rd_out = s_reg.mem_rd;
  assign mem_wr_out = s_reg.mem_wr;
  assign mem_addr_out = s_reg.mem_addr;
  assign mem_wdata_out = s_reg.wdata;
  assign pc_load_out = s_reg.pc_load;
  assign pc_target_out = s_reg.pc_target;
  assign flush_out = s_reg.flush;
  assign status_we_out = s_reg.status_we;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn);

  sequence seq_q3_exec(bbod_pkg::bbod_op_t o);
    ce_in && s_reg.phase == bbod_pkg::PH_Q3 && exec_now && s_reg.op == o;
  endsequence

  // stalls between the write and the nop cycle stay short
  sequence seq_taken_tail;
    pc_load_out && flush_out ##[1:4] (ce_in && nop_cycle_out);
  endsequence

  a_novf_branch_taken: assert property (
    seq_q3_exec(bbod_pkg::OP_BRANCH_NOT_OVERFLOW) and !ovf_flag_in |=> pc_load_out
  ) else $error("overflow-clear branch not taken");

  a_novf_branch_held: assert property (
    seq_q3_exec(bbod_pkg::OP_BRANCH_NOT_OVERFLOW) and ovf_flag_in |=> !pc_load_out && !flush_out
  ) else $error("overflow-clear branch taken with overflow set");

  a_nzero_branch_pick: assert property (
    seq_q3_exec(bbod_pkg::OP_BRANCH_NOT_ZERO) |=> pc_load_out == !$past(zero_flag_in)
  ) else $error("zero-clear branch decision wrong");

  a_nzero_branch_held: assert property (
    seq_q3_exec(bbod_pkg::OP_BRANCH_NOT_ZERO) and zero_flag_in |=> !pc_load_out && !flush_out
  ) else $error("zero-clear branch taken with zero set");

  a_target_twice_off: assert property (
    seq_q3_exec(bbod_pkg::OP_BRANCH_ALWAYS) |=>
      pc_target_out == $past(s_reg.pc_base) + {{9{$past(s_reg.off[10])}}, $past(s_reg.off), 1'b0}
  ) else $error("relative target not base plus twice offset");

  a_cond_target: assert property (
    seq_q3_exec(bbod_pkg::OP_BRANCH_NOT_ZERO) and !zero_flag_in |=>
      pc_target_out == $past(s_reg.pc_base) + {{12{$past(s_reg.off[7])}}, $past(s_reg.off[7:0]), 1'b0}
  ) else $error("short-offset target not base plus twice offset");

  a_taken_then_nop: assert property (
    (ce_in && s_reg.phase == bbod_pkg::PH_Q4 && pc_load_out) |=> nop_cycle_out && s_reg.phase == bbod_pkg::PH_Q1
  ) else $error("taken branch not followed by nop cycle");

  a_not_taken_single: assert property (
    (ce_in && s_reg.phase == bbod_pkg::PH_Q4 && exec_now && !s_reg.taken) |=> !nop_cycle_out
  ) else $error("untaken instruction followed by nop cycle");

  a_flush_with_load: assert property (
    pc_load_out |-> flush_out
  ) else $error("pc written without discarding prefetch");

  a_always_branch: assert property (
    seq_q3_exec(bbod_pkg::OP_BRANCH_ALWAYS) |=> seq_taken_tail
  ) else $error("unconditional branch not two cycles");

  a_set_bit_write: assert property (
    seq_q3_exec(bbod_pkg::OP_BIT_SET_FILE) |=>
      mem_wr_out && mem_wdata_out == ($past(rdata_in) | bbod_pkg::bit_mask($past(s_reg.bitpos))) && !flush_out
  ) else $error("bit set write data wrong");

  a_read_in_q2: assert property (
    mem_rd_out |-> s_reg.phase == bbod_pkg::PH_Q2
  ) else $error("file read outside its phase");

  a_write_in_q4: assert property (
    mem_wr_out |-> s_reg.phase == bbod_pkg::PH_Q4 && !pc_load_out && !flush_out
  ) else $error("file write outside its phase");

  a_access_bank: assert property (
    (mem_rd_out && !s_reg.bank_a) |->
      mem_addr_out[11:8] == (s_reg.faddr[7] ? bbod_pkg::ACCESS_HIGH_BANK : bbod_pkg::ACCESS_LOW_BANK)
  ) else $error("access bank not used");

  a_banked_addr: assert property (
    (ce_in && s_reg.phase == bbod_pkg::PH_Q1 && exec_now && dif.bank_a &&
     dif.op == bbod_pkg::OP_BIT_TEST_SKIP_CLEAR) |=> mem_rd_out && mem_addr_out[11:8] == $past(bank_select_register_in)
  ) else $error("bank select not used");

  a_skip_on_clear: assert property (
    seq_q3_exec(bbod_pkg::OP_BIT_TEST_SKIP_CLEAR) |=> flush_out == !$past(rdata_in[s_reg.bitpos]) && !pc_load_out
  ) else $error("skip decision wrong");

  a_skip_one_nop: assert property (
    (ce_in && s_reg.phase == bbod_pkg::PH_Q4 && exec_now && s_reg.taken && !two_word_next_in &&
     s_reg.op == bbod_pkg::OP_BIT_TEST_SKIP_CLEAR) |=> s_reg.nop_left == bbod_pkg::NOP_AFTER_TAKEN && nop_cycle_out
  ) else $error("one-word skip not one nop");

  a_nop_quiet: assert property (
    nop_cycle_out |-> !mem_rd_out && !mem_wr_out && !pc_load_out && !flush_out
  ) else $error("activity during nop cycle");

  a_skip_two_word: assert property (
    (ce_in && s_reg.phase == bbod_pkg::PH_Q4 && exec_now && s_reg.taken && two_word_next_in &&
     s_reg.op == bbod_pkg::OP_BIT_TEST_SKIP_CLEAR) |=> s_reg.nop_left == 2'h2 && nop_cycle_out
  ) else $error("two-word skip not two nops");

  a_status_kept: assert property (
    !status_we_out
  ) else $error("status write during this group");

  // state only moves on enabled edges
  a_ce_freeze_state: assert property (
    !ce_in |=> $stable(s_reg)
  ) else $error("state moved with clock enable low");

endmodule // bbod_core
`default_nettype wire

// [test_branch_bit_op_decode.sv]
// self-checking bench for the branch and bit-op execute core
// assumes bbod_core as top, one instruction per cycle, ce_in stalls only in the mixed test
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_branch_bit_op_decode;
  typedef struct packed {
    logic rd; logic pc_load; logic flush; logic wr; logic swe;
    logic [20:0] target; logic [11:0] addr; logic [7:0] wdata;
  } bbod_ev_t;
  localparam int LIMIT = 20000;
  logic clk_in, resetn_in, ce_in, two_word_next_in, ovf_flag_in, zero_flag_in;
  logic [15:0] instr_in;
  logic [20:0] pc_next_in, pc_target_out;
  logic [3:0] bank_select_register_in;
  logic [7:0] rdata_in, mem_wdata_out;
  logic [1:0] phase_out;
  logic nop_cycle_out, mem_rd_out, mem_wr_out, pc_load_out, flush_out, status_we_out;
  logic [11:0] mem_addr_out;
  int num_errors = 0, n_checks = 0, cycles = 0;
  bbod_ev_t evq[$];
  int nopq[$];
  logic [31:0] r;
  logic stall_on;

  bbod_core dut (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in), .instr_in(instr_in),
    .pc_next_in(pc_next_in), .two_word_next_in(two_word_next_in), .ovf_flag_in(ovf_flag_in),
    .zero_flag_in(zero_flag_in), .bank_select_register_in(bank_select_register_in),
    .rdata_in(rdata_in), .phase_out(phase_out), .nop_cycle_out(nop_cycle_out),
    .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out), .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out), .pc_load_out(pc_load_out), .pc_target_out(pc_target_out),
    .flush_out(flush_out), .status_we_out(status_we_out));

  // ---------------------------------------------------------------
  // clock and hang guard
  // ---------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      num_errors++;
      complete_run();
    end
  end

  // clock enable: never low two cycles running
  always @(posedge clk_in) ce_in <= !stall_on || !ce_in || (($urandom % 3) != 0);

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // driver: present one word, note what must come out
  // ---------------------------------------------------------------
  task automatic run_one(input logic [15:0] w, input logic [20:0] pc, input logic [3:0] bank_select_register,
      input logic ovf, input logic zf, input logic [7:0] rd, input logic tw);
    bbod_ev_t e;
    logic [11:0] ad;
    logic [2:0] b;
    int nops;
    e = '0;
    nops = 0;
    b = w[11:9];
    ad = w[8] ? {bank_select_register, w[7:0]} : {(w[7] ? 4'hf : 4'h0), w[7:0]};
    if ((w[15:8] == bbod_pkg::OPC_BR_NOT_OVF && !ovf) || (w[15:8] == bbod_pkg::OPC_BR_NOT_ZERO && !zf)) begin
      e.pc_load = 1'b1;
      e.flush = 1'b1;
      e.target = pc + {{12{w[7]}}, w[7:0], 1'b0};
      nops = 1;
    end else if (w[15:11] == bbod_pkg::OPC_BR_ALWAYS) begin
      e.pc_load = 1'b1;
      e.flush = 1'b1;
      e.target = pc + {{9{w[10]}}, w[10:0], 1'b0};
      nops = 1;
    end else if (w[15:12] == bbod_pkg::OPC_BIT_SET) begin
      e.rd = 1'b1;
      e.wr = 1'b1;
      e.addr = ad;
      e.wdata = rd | (8'h01 << b);
    end else if (w[15:12] == bbod_pkg::OPC_BIT_SKIP_CLR && !rd[b]) begin
      e.rd = 1'b1;
      e.flush = 1'b1;
      e.addr = ad;
      nops = tw ? 2 : 1;
    end
    do @(posedge clk_in); while (phase_out !== 2'h3 || ce_in !== 1'b1);
    instr_in <= w;
    pc_next_in <= pc;
    bank_select_register_in <= bank_select_register;
    do @(posedge clk_in); while (phase_out !== 2'h0 || nop_cycle_out !== 1'b0 || ce_in !== 1'b1);
    instr_in <= 16'h0000;
    ovf_flag_in <= ovf;
    zero_flag_in <= zf;
    rdata_in <= rd;
    two_word_next_in <= tw;
    if (e.pc_load || e.flush || e.wr) evq.push_back(e);
    nopq.push_back(nops);
  endtask

  // ---------------------------------------------------------------
  // monitor: compare each result with the oldest note
  // ---------------------------------------------------------------
  initial begin : monitor
    bbod_ev_t got, exp;
    int cnt, en;
    logic rd_seen;
    cnt = 0;
    rd_seen = 1'b0;
    forever begin
      do @(negedge clk_in); while (ce_in !== 1'b1);
      if (phase_out === 2'h1) rd_seen = mem_rd_out;
      if (phase_out === 2'h3) begin
        `CHECK(status_we_out, 1'b0)
        if ((pc_load_out | flush_out | mem_wr_out) === 1'b1) begin
          got = {rd_seen, pc_load_out, flush_out, mem_wr_out, status_we_out,
            pc_load_out ? pc_target_out : 21'h0, pc_load_out ? 12'h0 : mem_addr_out,
            mem_wr_out ? mem_wdata_out : 8'h0};
          `CHECK(evq.size() > 0, 1'b1)
          if (evq.size() > 0) begin
            exp = evq.pop_front();
            `CHECK(got, exp)
          end
        end
      end
      if (phase_out === 2'h0 && nop_cycle_out === 1'b1) cnt++;
      else if (phase_out === 2'h0) begin
        if (nopq.size() > 0) begin
          en = nopq.pop_front();
          `CHECK(cnt, en)
        end
        cnt = 0;
      end
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin : main
    logic [7:0] offs8[5];
    logic [10:0] offs11[5];
    logic [7:0] rd;
    offs8 = '{8'h80, 8'h7f, 8'h00, 8'hff, 8'h35};
    offs11 = '{11'h400, 11'h3ff, 11'h000, 11'h7ff, 11'h123};
    resetn_in = 1'b0;
    stall_on = 1'b0;
    instr_in = 16'h0000;
    pc_next_in = 21'h000000;
    bank_select_register_in = 4'h0;
    ovf_flag_in = 1'b0;
    zero_flag_in = 1'b0;
    rdata_in = 8'h00;
    two_word_next_in = 1'b0;
    void'($urandom(89133));
    repeat (20) @(posedge clk_in);
    resetn_in <= 1'b1;
    for (int i = 0; i < 5; i++) for (int k = 0; k < 4; k++) begin
      r = $urandom;
      run_one({k[1] ? bbod_pkg::OPC_BR_NOT_ZERO : bbod_pkg::OPC_BR_NOT_OVF, offs8[i]}, {r[20:1], 1'b0},
        r[24:21], k[1] ? r[25] : k[0], k[1] ? k[0] : r[25], r[31:24], r[26]);
    end
    $display("conditional branch test done");
    for (int i = 0; i < 5; i++) begin
      r = $urandom;
      run_one({bbod_pkg::OPC_BR_ALWAYS, offs11[i]}, {r[20:1], 1'b0}, r[24:21], r[25], r[26], r[31:24], r[27]);
    end
    $display("unconditional branch test done");
    for (int b = 0; b < 8; b++) for (int a = 0; a < 4; a++) begin
      r = $urandom;
      run_one({bbod_pkg::OPC_BIT_SET, b[2:0], a[0], a[1], r[6:0]}, {r[20:1], 1'b0}, r[24:21], r[25], r[26],
        r[31:24], r[27]);
    end
    $display("bit set test done");
    for (int b = 0; b < 8; b++) for (int m = 0; m < 4; m++) begin
      r = $urandom;
      rd = m[0] ? (r[31:24] | (8'h01 << b)) : (r[31:24] & ~(8'h01 << b));
      run_one({bbod_pkg::OPC_BIT_SKIP_CLR, b[2:0], r[8:0]}, {r[20:1], 1'b0}, r[24:21], r[25], r[26], rd, m[1]);
    end
    $display("bit test skip test done");
    stall_on <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      r = $urandom;
      case (r[18:16])
        3'h0: r[15:8] = bbod_pkg::OPC_BR_NOT_OVF;
        3'h1: r[15:8] = bbod_pkg::OPC_BR_NOT_ZERO;
        3'h2: r[15:11] = bbod_pkg::OPC_BR_ALWAYS;
        3'h3: r[15:12] = bbod_pkg::OPC_BIT_SET;
        3'h4: r[15:12] = bbod_pkg::OPC_BIT_SKIP_CLR;
        default: r[15:12] = r[15:12];
      endcase
      run_one(r[15:0], {r[31:12], 1'b0}, r[23:20], r[24], r[25], r[31:24], r[26]);
    end
    $display("mixed back-to-back test done");
    repeat (40) @(posedge clk_in);
    `CHECK(evq.size(), 0)
    `CHECK(nopq.size(), 0)
    complete_run();
  end
endmodule // test_branch_bit_op_decode
`default_nettype wire
